// ===== inc/cds_cfg.svh
// Summary of operation
// - select bit 0 individual, 1 global duty
// - one shared global duty value register
// - channels 1-4 switched by on bit or input
// - enable bits pick input gating or swap
// - global channels keep own skip settings
// - one frame steps all four internal duties
// - global and external duties never stepped
// - shared sign bit: 0 down, 1 up
// - step codes none, 4, 8, 16 LSB
// - stepping saturates at 00 and FF
// - F8..FE made by eight-state F7/FF pattern
// - fixed per-value F7 positions in pattern
// - skipping only in normal mode
// - skipping per internal channel, never external
// - skip_enable 0 off, 1 on
// - control inputs deglitched before use
// - external follows on bit; internal channel rise opens window, in fail mode a fail_window_on rise does
// - fail mode: inputs drive, external off
// - inputs wake device and control outputs
// - individual duty is eight bits
// - sub-100 percent change waits next period
// - no modulation in fail or clock fail
`ifndef CDS_CFG_SVH
`define CDS_CFG_SVH
`define CDS_DUTY_RST     8'h00
`define CDS_DUTY_MIN     8'h00
`define CDS_DUTY_MAX     8'hFF
`define CDS_SKIP_LOW     8'hF7
`define CDS_SKIP_FIRST   8'hF8
`define CDS_SKIP_LAST    8'hFE
`define CDS_STEP_4       8'h04
`define CDS_STEP_8       8'h08
`define CDS_STEP_16      8'h10
`define CDS_MASK_FE      8'h01
`define CDS_MASK_FD      8'h11
`define CDS_MASK_FC      8'h15
`define CDS_MASK_FB      8'h55
`define CDS_MASK_FA      8'h57
`define CDS_MASK_F9      8'h77
`define CDS_MASK_F8      8'h7F
`define CDS_DEGLITCH_CYC 4
`endif

// ===== inc/cds_pkg.sv
package cds_pkg;
  typedef logic [7:0] cds_duty_t;
  // Pulse-skipping pattern position, one-hot
  typedef enum logic [7:0] {
    CDS_S0 = 8'h01,
    CDS_S1 = 8'h02,
    CDS_S2 = 8'h04,
    CDS_S3 = 8'h08,
    CDS_S4 = 8'h10,
    CDS_S5 = 8'h20,
    CDS_S6 = 8'h40,
    CDS_S7 = 8'h80
  } cds_skip_t;
endpackage

// ===== verilog/cds_core.sv
`timescale 1ns/1ps
`include "cds_cfg.svh"
// Index 0..3 are internal channels 1-4, index 4 the external switch
module cds_core #(
  parameter int DG_CYCLES = `CDS_DEGLITCH_CYC
) (
  input  wire logic                    clock,
  input  wire logic                    rst,
  input  wire logic                    fail_mode,
  input  wire logic                    clock_fail,
  input  wire logic                    period_start,
  input  wire logic                    frame_end,
  input  wire logic [4:0]              channel_on,
  input  wire logic [4:0]              global_select,
  input  wire logic [3:0]              input_enable_lo,
  input  wire logic [3:0]              input_enable_hi,
  input  wire logic [3:0]              skip_enable,
  input  wire logic [3:0]              control_input_pin,
  input  wire logic [3:0]              fail_window_on,
  input  wire logic [4:0]              duty_wr,
  input  wire cds_pkg::cds_duty_t      duty_wdata,
  input  wire logic                    global_duty_wr,
  input  wire cds_pkg::cds_duty_t      global_duty_wdata,
  input  wire logic                    step_write,
  input  wire logic                    step_sign,
  input  wire logic [3:0]              step_hi,
  input  wire logic [3:0]              step_lo,
  output logic [4:0]                   channel_state,
  output logic [4:0]                   duty_source,
  output logic [3:0]                   window_start,
  output logic [3:0]                   filtered_control_input,
  output logic                         wake_request,
  output logic                         pwm_active,
  output cds_pkg::cds_duty_t [4:0]     individual_duty_value,
  output cds_pkg::cds_duty_t           global_duty_value,
  output cds_pkg::cds_duty_t [4:0]     applied_duty
);
  import cds_pkg::*;

  localparam int CW = $clog2(DG_CYCLES + 1);

  // Saturating step; never wraps past the rails
  function automatic cds_duty_t step_duty(cds_duty_t v, logic up,
                                          logic hi, logic lo);
    cds_duty_t st;
    st = `CDS_DUTY_MIN;
    unique case ({hi, lo})
      2'b10: st = `CDS_STEP_4;
      2'b01: st = `CDS_STEP_8;
      2'b11: st = `CDS_STEP_16;
      default: st = `CDS_DUTY_MIN;
    endcase
    if (up) begin
      step_duty = (v > `CDS_DUTY_MAX - st) ? `CDS_DUTY_MAX : v + st;
    end else begin
      step_duty = (v < st) ? `CDS_DUTY_MIN : v - st;
    end
  endfunction

  // True when this pattern position outputs the lower value
  function automatic logic skip_low(cds_duty_t v, cds_skip_t ph);
    logic [7:0] m;
    m = 8'h00;
    unique case (v)
      8'hFE: m = `CDS_MASK_FE;
      8'hFD: m = `CDS_MASK_FD;
      8'hFC: m = `CDS_MASK_FC;
      8'hFB: m = `CDS_MASK_FB;
      8'hFA: m = `CDS_MASK_FA;
      8'hF9: m = `CDS_MASK_F9;
      8'hF8: m = `CDS_MASK_F8;
      default: m = 8'h00;
    endcase
    skip_low = |(m & ph);
  endfunction

  logic [3:0]          filt_reg, filt_next;
  logic [3:0][CW-1:0]  dg_cnt_reg, dg_cnt_next;

  // Deglitch: a pin level must persist before it is believed
  always_comb begin
    filt_next   = filt_reg;
    dg_cnt_next = dg_cnt_reg;
    for (int i = 0; i < 4; i++) begin
      if (control_input_pin[i] == filt_reg[i]) begin
        dg_cnt_next[i] = '0;
      end else if (dg_cnt_reg[i] == CW'(DG_CYCLES - 1)) begin
        filt_next[i]   = control_input_pin[i];
        dg_cnt_next[i] = '0;
      end else begin
        dg_cnt_next[i] = dg_cnt_reg[i] + 1'b1;
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      filt_reg   <= '0;
      dg_cnt_reg <= '0;
    end else begin
      filt_reg   <= filt_next;
      dg_cnt_reg <= dg_cnt_next;
    end
  end

  logic [4:0] state_reg, state_next;
  logic [4:0] src_reg, src_next;
  logic [3:0] win_reg, win_next;
  logic [3:0] fw_prev_reg;

  // Channel switching and duty source; only filtered inputs used
  always_comb begin
    state_next = '0;
    src_next   = global_select;
    win_next   = '0;
    for (int i = 0; i < 4; i++) begin
      if (fail_mode) begin
        state_next[i] = filt_reg[i];
        win_next[i]   = fail_window_on[i] & ~fw_prev_reg[i];
      end else begin
        if (!channel_on[i]) begin
          state_next[i] = 1'b0;
        end else if (input_enable_hi[i]) begin
          state_next[i] = 1'b1;
          src_next[i]   = global_select[i] ^ filt_reg[i];
        end else if (input_enable_lo[i]) begin
          state_next[i] = filt_reg[i];
        end else begin
          state_next[i] = 1'b1;
        end
        win_next[i] = state_next[i] & ~state_reg[i];
      end
    end
    // External switch ignores inputs, off in fail mode
    state_next[4] = channel_on[4] & ~fail_mode;
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_reg   <= '0;
      src_reg     <= '0;
      win_reg     <= '0;
      fw_prev_reg <= '0;
    end else begin
      state_reg   <= state_next;
      src_reg     <= src_next;
      win_reg     <= win_next;
      fw_prev_reg <= fail_window_on;
    end
  end

  cds_duty_t [4:0] ind_reg, ind_next;
  cds_duty_t       glob_reg, glob_next;

  // Duty storage; bulk step touches internal channels only
  always_comb begin
    ind_next  = ind_reg;
    glob_next = glob_reg;
    if (global_duty_wr) begin
      glob_next = global_duty_wdata;
    end
    if (frame_end && step_write) begin
      for (int i = 0; i < 4; i++) begin
        ind_next[i] = step_duty(ind_reg[i], step_sign,
                                step_hi[i], step_lo[i]);
      end
    end
    // A direct write in the same cycle wins over a step
    for (int i = 0; i < 5; i++) begin
      if (duty_wr[i]) begin
        ind_next[i] = duty_wdata;
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ind_reg  <= {5{`CDS_DUTY_RST}};
      glob_reg <= `CDS_DUTY_RST;
    end else begin
      ind_reg  <= ind_next;
      glob_reg <= glob_next;
    end
  end

  cds_skip_t phase_reg, phase_next;

  // Pattern position steps once per period
  always_comb begin
    phase_next = phase_reg;
    if (period_start) begin
      unique case (phase_reg)
        CDS_S0: phase_next = CDS_S1;
        CDS_S1: phase_next = CDS_S2;
        CDS_S2: phase_next = CDS_S3;
        CDS_S3: phase_next = CDS_S4;
        CDS_S4: phase_next = CDS_S5;
        CDS_S5: phase_next = CDS_S6;
        CDS_S6: phase_next = CDS_S7;
        CDS_S7: phase_next = CDS_S0;
        default: phase_next = CDS_S0;
      endcase
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      phase_reg <= CDS_S0;
    end else begin
      phase_reg <= phase_next;
    end
  end

  cds_duty_t [4:0] sel_duty;
  cds_duty_t [4:0] app_reg, app_next;

  // Full duty applies at once; anything lower waits for the period
  always_comb begin
    app_next = app_reg;
    for (int i = 0; i < 5; i++) begin
      sel_duty[i] = src_reg[i] ? glob_reg : ind_reg[i];
    end
    for (int i = 0; i < 5; i++) begin
      if (period_start || sel_duty[i] == `CDS_DUTY_MAX) begin
        app_next[i] = sel_duty[i];
      end
    end
    // Skipping puts out only F7 or full; the external never skips
    for (int i = 0; i < 4; i++) begin
      if (period_start && skip_enable[i] && !fail_mode
          && sel_duty[i] >= `CDS_SKIP_FIRST
          && sel_duty[i] <= `CDS_SKIP_LAST) begin
        app_next[i] = skip_low(sel_duty[i], phase_reg)
                    ? `CDS_SKIP_LOW : `CDS_DUTY_MAX;
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      app_reg <= {5{`CDS_DUTY_RST}};
    end else begin
      app_reg <= app_next;
    end
  end

  // Outputs straight from flops, except the wake OR and the mode level
  assign channel_state          = state_reg;
  assign duty_source            = src_reg;
  assign window_start           = win_reg;
  assign filtered_control_input = filt_reg;
  assign wake_request           = |filt_reg;
  assign pwm_active             = ~fail_mode & ~clock_fail;
  assign individual_duty_value  = ind_reg;
  assign global_duty_value      = glob_reg;
  assign applied_duty           = app_reg;

  // Checks
  wire logic step0 = frame_end && step_write && !duty_wr[0];

  ext_untouched_a: assert property (
    @(posedge clock) disable iff (rst)
    frame_end && step_write && !duty_wr[4] && !global_duty_wr
    |=> $stable(ind_reg[4]) && $stable(glob_reg))
    else $error("step changed external or global duty");
  step_up_a: assert property (
    @(posedge clock) disable iff (rst)
    step0 && step_sign |=> ind_reg[0] >= $past(ind_reg[0]))
    else $error("increment wrapped below old value");
  step_down_a: assert property (
    @(posedge clock) disable iff (rst)
    step0 && !step_sign |=> ind_reg[0] <= $past(ind_reg[0]))
    else $error("decrement raised the duty");
  step_none_a: assert property (
    @(posedge clock) disable iff (rst)
    step0 && !step_hi[0] && !step_lo[0] |=> $stable(ind_reg[0]))
    else $error("zero step code changed duty");
  fail_ext_off_a: assert property (
    @(posedge clock) disable iff (rst)
    fail_mode |=> !channel_state[4])
    else $error("external channel on in fail mode");
  on_bit_off_a: assert property (
    @(posedge clock) disable iff (rst)
    !fail_mode && !channel_on[0] |=> !channel_state[0])
    else $error("channel on while on bit clear");
  deglitch_hold_a: assert property (
    @(posedge clock) disable iff (rst)
    $changed(filt_reg[0]) |-> $past(control_input_pin[0]) == filt_reg[0]
      && $past(control_input_pin[0], 2) == filt_reg[0])
    else $error("filter followed a short pulse");
  skip_first_a: assert property (
    @(posedge clock) disable iff (rst)
    period_start && skip_enable[0] && !fail_mode
      && sel_duty[0] == `CDS_SKIP_LAST && phase_reg == CDS_S0
    |=> applied_duty[0] == `CDS_SKIP_LOW)
    else $error("pattern slot S0 not low for FE");
  // Unskipped slots must show full duty, not the raw value
  skip_high_a: assert property (
    @(posedge clock) disable iff (rst)
    period_start && skip_enable[0] && !fail_mode
      && sel_duty[0] == `CDS_SKIP_LAST && phase_reg != CDS_S0
    |=> applied_duty[0] == `CDS_DUTY_MAX)
    else $error("pattern slot after S0 not full for FE");
  window_rise_a: assert property (
    @(posedge clock) disable iff (rst)
    !fail_mode && !$past(fail_mode) && $rose(channel_state[0])
    |-> window_start[0])
    else $error("rising channel without window start");
  phase_wrap_a: assert property (
    @(posedge clock) disable iff (rst)
    period_start && phase_reg == CDS_S7 |=> phase_reg == CDS_S0)
    else $error("pattern did not wrap to S0");

  bulk_up_c: cover property (@(posedge clock) disable iff (rst)
    step0 && step_sign && ind_reg[0] == `CDS_DUTY_MAX);
  swap_c: cover property (@(posedge clock) disable iff (rst)
    input_enable_hi[0] && filt_reg[0] && channel_on[0]);
  skip_c: cover property (@(posedge clock) disable iff (rst)
    app_reg[1] == `CDS_SKIP_LOW && skip_enable[1]);
  fail_win_c: cover property (@(posedge clock) disable iff (rst)
    fail_mode && win_reg[1]);
endmodule

// ===== testbench/cds_host_model.sv
`timescale 1ns/1ps
// Host side pacing: one PWM period every PERIOD reference cycles
module cds_host_model #(
  parameter int PERIOD = 6
) (
  input  wire logic clock,
  input  wire logic rst,
  output logic      period_start
);
  int cnt;
  // One-cycle period pulse, restarted by reset so phase S0 lines up
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cnt <= 0;
      period_start <= 1'b0;
    end else begin
      cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
      period_start <= (cnt == PERIOD - 1);
    end
  end
endmodule

// ===== testbench/testbench.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin \
  failures++; $display("[FAIL] %s exp %h got %h", n, e, g); end end
module testbench;
  import cds_pkg::*;
  localparam int DG = 2;
  logic            clock = 0, rst = 1, fail_mode = 0, clock_fail = 0;
  logic            frame_end = 0, step_write = 0, step_sign = 0;
  logic            global_duty_wr = 0, period_start, wake_request;
  logic            pwm_active;
  logic [4:0]      channel_on = 0, global_select = 0, duty_wr = 0;
  logic [4:0]      channel_state, duty_source;
  logic [3:0]      input_enable_lo = 0, input_enable_hi = 0;
  logic [3:0]      skip_enable = 0, control_input_pin = 0;
  logic [3:0]      fail_window_on = 0, step_hi = 0, step_lo = 0;
  logic [3:0]      window_start, filtered_control_input;
  cds_duty_t       duty_wdata = 0, global_duty_wdata = 0;
  cds_duty_t       global_duty_value, e, v;
  cds_duty_t [4:0] individual_duty_value, applied_duty;
  cds_duty_t       dv [6];
  logic [7:0]      m;
  int              failures = 0, checked = 0, pcount = 0;

  // Short deglitch keeps the random loop fast
  cds_core #(.DG_CYCLES(DG)) i_cds_core (
    .clock, .rst, .fail_mode, .clock_fail, .period_start, .frame_end,
    .channel_on, .global_select, .input_enable_lo, .input_enable_hi,
    .skip_enable, .control_input_pin, .fail_window_on, .duty_wr,
    .duty_wdata, .global_duty_wr, .global_duty_wdata, .step_write,
    .step_sign, .step_hi, .step_lo, .channel_state, .duty_source,
    .window_start, .filtered_control_input, .wake_request, .pwm_active,
    .individual_duty_value, .global_duty_value, .applied_duty
  );
  cds_host_model #(.PERIOD(6)) i_host (
    .clock, .rst, .period_start
  );

  always #10 clock = ~clock;
  // Periods seen since reset give the expected pattern slot
  always @(posedge clock or posedge rst) begin
    if (rst) pcount <= 0;
    else if (period_start) pcount <= pcount + 1;
  end

  task automatic conclude;
    if (failures == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic cyc(int n);
    repeat (n) @(negedge clock);
  endtask
  // Index 5 is the global value; 1 << 5 clears every channel strobe
  task automatic wr(int c, cds_duty_t d);
    @(negedge clock);
    global_duty_wr = (c == 5);
    duty_wr = 5'(1 << c);
    duty_wdata = d;
    global_duty_wdata = d;
    @(negedge clock);
    global_duty_wr = 1'b0;
    duty_wr = 5'h0;
  endtask
  function automatic cds_duty_t stepv(cds_duty_t d, logic s, h, l);
    int r;
    r = (h && l) ? 16 : h ? 4 : l ? 8 : 0;
    r = s ? d + r : d - r;
    r = r > 255 ? 255 : r < 0 ? 0 : r;
    return r[7:0];
  endfunction
  function automatic logic [7:0] skipmask(cds_duty_t d);
    case (d)
      8'hFE: return 8'h01;
      8'hFD: return 8'h11;
      8'hFC: return 8'h15;
      8'hFB: return 8'h55;
      8'hFA: return 8'h57;
      8'hF9: return 8'h77;
      8'hF8: return 8'h7F;
      default: return 8'h00;
    endcase
  endfunction
  task automatic chk_ctl;
    logic [4:0] st, src;
    for (int i = 0; i < 4; i++) begin
      st[i] = fail_mode ? control_input_pin[i] : channel_on[i] &
        (input_enable_hi[i] | ~input_enable_lo[i] | control_input_pin[i]);
      src[i] = global_select[i] ^ (channel_on[i] & input_enable_hi[i]
        & control_input_pin[i]);
    end
    st[4] = channel_on[4] & ~fail_mode;
    src[4] = global_select[4];
    `CHK("state", st, channel_state)
    if (!fail_mode) `CHK("source", src, duty_source)
    `CHK("filtered", control_input_pin, filtered_control_input)
    `CHK("wake", |control_input_pin, wake_request)
    `CHK("active", ~fail_mode & ~clock_fail, pwm_active)
  endtask
  // Frame end with a step, none for k 2; settle a few cycles to catch repeats
  task automatic step(int k);
    logic s, w;
    logic [3:0] h, l;
    s = k == 1 ? 1'b1 : k == 0 ? 1'b0 : 1'($urandom);
    h = k < 2 ? 4'hF : 4'($urandom);
    l = k == 1 ? 4'hF : k == 0 ? 4'h0 : 4'($urandom);
    w = (k != 2);
    @(negedge clock);
    frame_end = 1'b1;
    step_write = w;
    step_sign = s;
    step_hi = h;
    step_lo = l;
    @(negedge clock);
    frame_end = 1'b0;
    cyc(3);
    for (int c = 0; c < 4; c++) begin
      e = w ? stepv(dv[c], s, h[c], l[c]) : dv[c];
      `CHK("step", e, individual_duty_value[c])
    end
    `CHK("ext", dv[4], individual_duty_value[4])
    `CHK("glob", dv[5], global_duty_value)
  endtask
  task automatic wait_period;
    int t;
    for (t = 0; t < 40 && period_start !== 1'b1; t++) @(negedge clock);
    if (t == 40) begin
      failures++;
      conclude();
    end
    @(negedge clock);
  endtask

  initial begin
    void'($urandom(32'h7d33));
    repeat (20) @(negedge clock);
    rst = 1'b0;
    // Random control mixes; a one-cycle glitch must not get through
    for (int k = 0; k < 80; k++) begin
      @(negedge clock);
      {channel_on, global_select, input_enable_lo, input_enable_hi} =
        18'($urandom);
      control_input_pin = 4'($urandom);
      fail_mode = ($urandom % 4 == 0);
      clock_fail = 1'($urandom);
      cyc(DG + 2);
      control_input_pin[0] = ~control_input_pin[0];
      cyc(1);
      control_input_pin[0] = ~control_input_pin[0];
      cyc(1);
      chk_ctl();
    end
    // Window pulses from the on bit, then from fail-mode control
    {fail_mode, clock_fail, channel_on, input_enable_lo} = 0;
    fail_window_on = 4'h0;
    cyc(3);
    channel_on[2] = 1'b1;
    cyc(1);
    `CHK("win_on", 4'h4, window_start)
    cyc(1);
    `CHK("win_end", 4'h0, window_start)
    fail_mode = 1'b1;
    cyc(3);
    fail_window_on[1] = 1'b1;
    cyc(1);
    `CHK("win_fail", 4'h2, window_start)
    // Bulk steps: rail corners first, then random values and codes
    fail_mode = 1'b0;
    for (int k = 0; k < 30; k++) begin
      for (int c = 0; c < 6; c++) begin
        dv[c] = k == 0 ? 8'h02 : k == 1 ? 8'hFA : 8'($urandom);
        wr(c, dv[c]);
      end
      step(k);
    end
    // Ch2 takes global duty but keeps its own skip bit
    channel_on = 5'h1F;
    global_select = 5'h02;
    input_enable_hi = 4'h0;
    skip_enable = 4'h3;
    for (int j = 0; j < 9; j++) begin
      v = j == 8 ? 8'hFE : 8'(8'hFF - j);
      fail_mode = (j == 8);
      m = skipmask(v);
      for (int c = 0; c < 6; c++) begin
        wr(c, v);
      end
      repeat (8) begin
        wait_period();
        for (int c = 0; c < 5; c++) begin
          // Skipped slots give F7, the rest of the pattern full duty
          e = (c < 2 && !fail_mode && m != 8'h00)
            ? (m[(pcount - 1) % 8] ? 8'hF7 : 8'hFF) : v;
          `CHK("skip", e, applied_duty[c])
        end
      end
    end
    conclude();
  end
endmodule
